// ---- include/ftb_pkg.sv ----
// Package: constants, register map and state types of the flash timebase block
package ftb_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int          ADDR_W      = 18;          // Byte address width on the bus
    localparam int          IDX_W       = 16;          // Register index width
    localparam int          DATA_W      = 32;          // Bus data width

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [15:0] DIV_IDX     = 16'h1820;    // flash_clock_divider
    localparam logic [15:0] OPT_IDX     = 16'h1821;    // option_working_copy
    localparam logic [15:0] NVIMG_IDX   = 16'hffbf;    // option_nonvolatile_image

    // ==========================================================
    // Field layout of flash_clock_divider
    // ==========================================================
    localparam int          LOADED_BIT  = 7;           // divisor_loaded_flag
    localparam int          PRESC_BIT   = 6;           // prescale_by_eight
    localparam int          DIV_W       = 6;           // Divisor field width
    localparam logic [7:0]  DIV_RST     = 8'h00;       // Value after reset

    // ==========================================================
    // Field layout of the option registers
    // ==========================================================
    localparam logic [7:0]  OPT_MASK    = 8'hc3;       // Bits 5..2 read as zero
    localparam int          KEY_EN_BIT  = 7;           // backdoor_key_enable
    localparam int          NORED_BIT   = 6;           // vector_redirect_disable
    localparam logic [1:0]  SEC_OPEN    = 2'h2;        // Only unsecured code

    // ==========================================================
    // Timebase counts
    // ==========================================================
    localparam logic [2:0]  PRE_LAST    = 3'h7;        // Last state of divide-by-eight
    localparam int          PER_W       = 10;          // Width of the period checker

    // ==========================================================
    // Bus answers
    // ==========================================================
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================
    // State types
    // ==========================================================
    typedef enum logic [1:0] {
        FTB_W_COLLECT = 2'b01,                         // Gathering address and data
        FTB_W_RESP    = 2'b10                          // Write answer pending
    } ftb_wr_state_t;

    typedef enum logic [1:0] {
        FTB_R_IDLE    = 2'b01,                         // Ready for an address
        FTB_R_RESP    = 2'b10                          // Read data pending
    } ftb_rd_state_t;

endpackage

// ---- hw/ftb_top.sv ----
// Flash timebase, erase/program gate and option register with AXI4-Lite slave
`timescale 1ns/1ps

// Summary of operation
// - Reset clears loaded flag; first user-mode write sets it
// - Refuse erase or program while flag clear
// - Prescale bit selects bus clock or clock/8
// - User mode: prescale bit written once only
// - Timing clock is input over divisor plus one
// - Each timing pulse is one timing period
// - Test mode: fields writable while done flag set
// - Reset copies nonvolatile option byte into working copy
// - Option bits 5 to 2 read zero
// - Option working copy ignores bus writes
// - Security open only for code binary 10
// - Key enable bit 7 permits backdoor unlocking
// - Redirect disable bit 6 clear enables redirection
module ftb_top
    import ftb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Flash array side
    input  wire logic [7:0]        option_nonvolatile_image,
    input  wire logic              test_mode,
    input  wire logic              operation_done_flag,
    input  wire logic              op_request,
    output logic                   op_grant,
    output logic                   op_refused,
    output logic                   flash_timing_clock,
    output logic                   secured,
    output logic                   backdoor_key_enable,
    output logic                   vector_redirect_enable
);

    // ==========================================================
    // Declarations
    // ==========================================================
    ftb_wr_state_t          wr_state_r;                 // Write channel state
    ftb_rd_state_t          rd_state_r;                 // Read channel state
    logic                   aw_have_r;                  // Write address held
    logic                   w_have_r;                   // Write data held
    logic [IDX_W-1:0]       aw_idx_r;                   // Held write index
    logic [7:0]             w_byte_r;                   // Held write byte
    logic                   w_lane_r;                   // Byte lane 0 enabled
    logic                   wr_do;                      // Write performed now
    logic                   wr_div;                     // Divider register written
    logic [IDX_W-1:0]       ar_idx;                     // Read index
    logic                   divisor_loaded_flag_r;                    // divisor_loaded_flag
    logic                   presc_r;                    // prescale_by_eight
    logic [DIV_W-1:0]       div_r;                      // Divisor field
    logic [7:0]             opt_r;                      // option_working_copy
    logic [2:0]             pre_cnt_r;                  // Divide-by-eight counter
    logic [DIV_W-1:0]       div_cnt_r;                  // Main divider counter
    logic                   step;                       // Divider input edge
    logic                   wrap;                       // Divider completes a period
    logic [PER_W-1:0]       per_cnt_r;                  // Cycles into the period

    assign wr_do  = ce && (wr_state_r == FTB_W_COLLECT) && aw_have_r && w_have_r;
    assign wr_div = wr_do && w_lane_r && (aw_idx_r == DIV_IDX);
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign step   = !presc_r || (pre_cnt_r == PRE_LAST);
    assign wrap   = step && (div_cnt_r == div_r);

    // ==========================================================
    // AXI write channel
    // ==========================================================
    // Address and data are taken in either order, then answered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_state_r    <= FTB_W_COLLECT;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_idx_r      <= '0;
            w_byte_r      <= '0;
            w_lane_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (ce) begin
            unique case (wr_state_r)
                FTB_W_COLLECT: begin
                    // Capture the address
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_idx_r      <= s_axi_awaddr[ADDR_W-1:2];
                        aw_have_r     <= 1'b1;
                        s_axi_awready <= 1'b0;
                    end
                    // Capture the data
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_byte_r     <= s_axi_wdata[7:0];
                        w_lane_r     <= s_axi_wstrb[0];
                        w_have_r     <= 1'b1;
                        s_axi_wready <= 1'b0;
                    end
                    // Both present: answer, unmapped gets an error
                    if (aw_have_r && w_have_r) begin
                        aw_have_r    <= 1'b0;
                        w_have_r     <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (aw_idx_r == DIV_IDX || aw_idx_r == OPT_IDX ||
                                         aw_idx_r == NVIMG_IDX) ? RESP_OKAY : RESP_SLVERR;
                        wr_state_r   <= FTB_W_RESP;
                    end
                end
                FTB_W_RESP: begin
                    // Answer taken: reopen both channels
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        wr_state_r    <= FTB_W_COLLECT;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // AXI read channel
    // ==========================================================
    // Data is registered on the same edge that takes the address
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_state_r    <= FTB_R_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            unique case (rd_state_r)
                FTB_R_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rresp   <= RESP_OKAY;
                        rd_state_r    <= FTB_R_RESP;
                        // Register selection
                        if (ar_idx == DIV_IDX) begin
                            s_axi_rdata <= {24'h000000, divisor_loaded_flag_r, presc_r, div_r};
                        end else if (ar_idx == OPT_IDX) begin
                            s_axi_rdata <= {24'h000000, opt_r};
                        end else if (ar_idx == NVIMG_IDX) begin
                            s_axi_rdata <= {24'h000000,
                                            option_nonvolatile_image & OPT_MASK};
                        end else begin
                            s_axi_rdata <= '0;
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                end
                FTB_R_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state_r    <= FTB_R_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Clock divider register
    // ==========================================================
    // User mode latches all fields once; test mode writes while done
    always_ff @(posedge clk) begin
        if (!nrst) begin
            divisor_loaded_flag_r <= DIV_RST[LOADED_BIT];
            presc_r <= DIV_RST[PRESC_BIT];
            div_r   <= DIV_RST[DIV_W-1:0];
        end else if (wr_div) begin
            if (test_mode) begin
                // Free access only while no operation runs
                if (operation_done_flag) begin
                    divisor_loaded_flag_r <= w_byte_r[LOADED_BIT];
                    presc_r <= w_byte_r[PRESC_BIT];
                    div_r   <= w_byte_r[DIV_W-1:0];
                end
            end else if (!divisor_loaded_flag_r) begin
                divisor_loaded_flag_r <= 1'b1;
                presc_r <= w_byte_r[PRESC_BIT];
                div_r   <= w_byte_r[DIV_W-1:0];
            end
        end
    end

    // ==========================================================
    // Option working copy
    // ==========================================================
    // Reloaded only by reset; bus writes never reach it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opt_r                  <= option_nonvolatile_image & OPT_MASK;
            secured                <= option_nonvolatile_image[1:0] != SEC_OPEN;
            backdoor_key_enable    <= option_nonvolatile_image[KEY_EN_BIT];
            vector_redirect_enable <= !option_nonvolatile_image[NORED_BIT];
        end
    end

    // ==========================================================
    // Timebase
    // ==========================================================
    // Prescaler then divider; a divider write restarts the period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_cnt_r          <= '0;
            div_cnt_r          <= '0;
            flash_timing_clock <= 1'b0;
        end else if (ce) begin
            if (wr_div) begin
                pre_cnt_r          <= '0;
                div_cnt_r          <= '0;
                flash_timing_clock <= 1'b0;
            end else begin
                pre_cnt_r          <= presc_r ? pre_cnt_r + 3'h1 : 3'h0;
                flash_timing_clock <= wrap;
                if (wrap) begin
                    div_cnt_r <= '0;
                end else if (step) begin
                    div_cnt_r <= div_cnt_r + 6'h01;
                end
            end
        end
    end

    // ==========================================================
    // Erase and program gate
    // ==========================================================
    // Requests are granted only once the divisor has been loaded
    always_ff @(posedge clk) begin
        if (!nrst) begin
            op_grant   <= 1'b0;
            op_refused <= 1'b0;
        end else if (ce) begin
            op_grant   <= op_request && divisor_loaded_flag_r;
            op_refused <= op_request && !divisor_loaded_flag_r;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Period checker counts clock-enabled cycles within a period
    always_ff @(posedge clk) begin
        if (!nrst || (ce && (wr_div || wrap))) begin
            per_cnt_r <= '0;
        end else if (ce) begin
            per_cnt_r <= per_cnt_r + 10'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    flag_reset_a:   assert property ($rose(nrst) |-> !divisor_loaded_flag_r && !presc_r && div_r == 6'h00)
        else $error("Divider fields not clear after reset");
    flag_set_a:     assert property (wr_div && !test_mode |=> divisor_loaded_flag_r)
        else $error("Loaded flag not set by user write");
    gate_refuse_a:  assert property (ce && op_request && !divisor_loaded_flag_r |=> op_refused && !op_grant)
        else $error("Request not refused before divisor load");
    gate_grant_a:   assert property (ce && op_request && divisor_loaded_flag_r |=> op_grant && !op_refused)
        else $error("Request not granted after divisor load");
    write_once_a:   assert property (wr_div && !test_mode && divisor_loaded_flag_r |=>
                        $stable(presc_r) && $stable(div_r))
        else $error("User write changed a write-once field");
    period_len_a:   assert property (ce && wrap |->
                        per_cnt_r + 10'h001 ==
                        ({4'h0, div_r} + 10'h001) * (presc_r ? 10'h008 : 10'h001))
        else $error("Timing period length wrong");
    tick_follow_a:  assert property (ce && wrap && !wr_div |=> flash_timing_clock)
        else $error("Timing pulse missing at period end");
    test_write_a:   assert property (wr_div && test_mode && operation_done_flag |=>
                        {divisor_loaded_flag_r, presc_r, div_r} == $past(w_byte_r))
        else $error("Test-mode write not stored");
    test_block_a:   assert property (wr_div && test_mode && !operation_done_flag |=>
                        $stable({divisor_loaded_flag_r, presc_r, div_r}))
        else $error("Test-mode write taken while busy");
    opt_load_a:     assert property ($rose(nrst) |->
                        opt_r == ($past(option_nonvolatile_image) & OPT_MASK))
        else $error("Option copy not loaded at reset");
    opt_hold_a:     assert property (wr_do |=> $stable(opt_r))
        else $error("Option copy changed by a write");
    sec_decode_a:   assert property (secured == (opt_r[1:0] != SEC_OPEN) &&
                        backdoor_key_enable == opt_r[KEY_EN_BIT] &&
                        vector_redirect_enable == !opt_r[NORED_BIT])
        else $error("Option outputs disagree with copy");

    grant_c:    cover property (ce && op_request && divisor_loaded_flag_r);
    refuse_c:   cover property (ce && op_request && !divisor_loaded_flag_r);
    presc_c:    cover property (ce && wrap && presc_r);
    test_wr_c:  cover property (wr_div && test_mode && operation_done_flag);

endmodule

// ---- bench/ftb_flash_model.sv ----
// Behavioural flash array and programming logic on the far side of the timebase block
`timescale 1ns/1ps

// ==========================================================
// Flash array model
// ==========================================================
module ftb_flash_model
    import ftb_pkg::*;
#(
    parameter int PULSES = 3                         // Timing pulses per erase or program
)(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,                   // Software asks for an operation
    input  wire logic       load_image,              // Reprogram the option byte
    input  wire logic [7:0] new_image,               // Byte to program
    input  wire logic       flash_timing_clock,
    input  wire logic       op_grant,
    output logic            op_request,
    output logic            operation_done_flag,
    output logic [7:0]      option_nonvolatile_image
);
    int cnt_r;                                       // Pulses left in the operation

    // Option byte changes only by reprogramming; a reset then reloads it
    always_ff @(posedge clk) begin
        if (load_image) begin
            option_nonvolatile_image <= new_image;
        end
    end

    // One request per start; a granted operation lasts whole timing pulses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            op_request <= 1'b0;
            operation_done_flag <= 1'b1;
            cnt_r <= 0;
        end else begin
            op_request <= start;
            if (op_grant) begin
                operation_done_flag <= 1'b0;
                cnt_r <= PULSES;
            end else if (!operation_done_flag && flash_timing_clock) begin
                operation_done_flag <= (cnt_r == 1);
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule

// ---- bench/testbench.sv ----
// Self-checking testbench of the flash timebase and option register block
`timescale 1ns/1ps

module testbench;
    import ftb_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic              clk, nrst, ce, test_mode, start, load_image;
    logic [7:0]        new_image, option_nonvolatile_image, img, v;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              op_request, op_grant, op_refused, flash_timing_clock;
    logic              operation_done_flag, secured, backdoor_key_enable;
    logic              vector_redirect_enable;
    int                fail_count, checked, seed;

    ftb_top i_dut (.clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .option_nonvolatile_image, .test_mode, .operation_done_flag, .op_request,
        .op_grant, .op_refused, .flash_timing_clock, .secured, .backdoor_key_enable,
        .vector_redirect_enable);

    ftb_flash_model #(.PULSES(3)) i_flash (.clk, .nrst, .start, .load_image, .new_image,
        .flash_timing_clock, .op_grant, .op_request, .operation_done_flag,
        .option_nonvolatile_image);

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Longest run is under twenty thousand cycles
    initial begin
        #500000;
        fail_count++;
        conclude();
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write one byte; address and data released as each is taken
    task wchk(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        bit ad, dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                dd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    // Read one word and compare data and response
    task rchk(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, e});
        chk(s_axi_rresp, er);
    endtask

    // Start request through the flash model, answer two edges later
    task req(input logic g);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        chk({op_grant, op_refused}, {g, !g});
    endtask

    // Cycles between two timing pulses
    task per(input int exp);
        int n;
        n = 0;
        do @(posedge clk); while (!flash_timing_clock);
        do begin
            @(posedge clk);
            n++;
        end while (!flash_timing_clock);
        chk(n, exp);
    endtask

    // Reprogram the option byte in the first of four reset cycles
    task rst;
        nrst <= 1'b0;
        load_image <= 1'b1;
        @(posedge clk);
        load_image <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    task conclude;
        $display("Mismatches %0d, comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        seed = 32'h2ddab5d9;
        {test_mode, start} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        ce = 1'b1;
        // Every security code, random other option bits, reprogram then reset
        for (int i = 0; i < 4; i++) begin
            img = 8'($random(seed));
            img[1:0] = i[1:0];
            new_image <= img;
            rst();
            rchk(OPT_IDX, img & OPT_MASK, RESP_OKAY);
            rchk(NVIMG_IDX, img & OPT_MASK, RESP_OKAY);
            chk(secured, i != 2);
            chk(backdoor_key_enable, img[7]);
            chk(vector_redirect_enable, !img[6]);
            wchk(OPT_IDX, ~img, RESP_OKAY);
            rchk(OPT_IDX, img & OPT_MASK, RESP_OKAY);
        end
        // User mode: gate closed until the first divider write
        // A write without byte lane 0 is no divider write
        s_axi_wstrb <= 4'he;
        wchk(DIV_IDX, 8'h7f, RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        rchk(DIV_IDX, 8'h00, RESP_OKAY);
        req(1'b0);
        wchk(DIV_IDX, 8'h7f, RESP_OKAY);
        rchk(DIV_IDX, 8'hff, RESP_OKAY);
        per(512);
        req(1'b1);
        v = 8'($random(seed));
        wchk(DIV_IDX, v, RESP_OKAY);
        rchk(DIV_IDX, 8'hff, RESP_OKAY);
        wchk(16'h1822, v, RESP_SLVERR);
        rchk(16'h1822, 8'h00, RESP_SLVERR);
        // Test mode: writes only while no operation runs
        test_mode <= 1'b1;
        req(1'b1);
        wchk(DIV_IDX, 8'h03, RESP_OKAY);
        rchk(DIV_IDX, 8'hff, RESP_OKAY);
        do @(posedge clk); while (!operation_done_flag);
        wchk(DIV_IDX, 8'h03, RESP_OKAY);
        rchk(DIV_IDX, 8'h03, RESP_OKAY);
        per(4);
        // Clock enable low: a request is not seen and nothing moves
        ce <= 1'b0;
        start <= 1'b1;
        repeat (3) @(posedge clk);
        chk({op_grant, op_refused}, 2'b00);
        start <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        req(1'b0);
        // Random settings against the integer model of the timebase
        for (int k = 0; k < 6; k++) begin
            do @(posedge clk); while (!operation_done_flag);
            v = 8'($random(seed));
            wchk(DIV_IDX, v, RESP_OKAY);
            rchk(DIV_IDX, v, RESP_OKAY);
            per((int'(v[5:0]) + 1) * (v[6] ? 8 : 1));
            req(v[7]);
        end
        conclude();
    end
endmodule
